// *** hdl/msi_caps_map.vh ***
// Register offsets, field positions and reset values for the interrupt and subsystem capability block
`ifndef MSI_CAPS_MAP_VH
`define MSI_CAPS_MAP_VH
`define OFS_CAP_CTRL      8'hd0
`define OFS_ADDR_LOW      8'hd4
`define OFS_ADDR_HIGH     8'hd8
`define OFS_PAYLOAD       8'hdc
`define OFS_SUB_HDR       8'hf0
`define OFS_SUB_IDS       8'hf4
`define OFS_UNLOCK        8'he0
`define OFS_IRQ_STATUS    8'he4
`define OFS_IRQ_MASK      8'he8
`define OFS_EVENT         8'hec
`define MSI_CAP_ID        8'h05
`define SUB_CAP_ID        8'h0d
`define LINK_RESET        8'h00
`define ENABLE_BIT        16
`define WIDE_BIT          23
`define ENABLE_RESET      1'b0
`define ADDR_RESET        30'h00000000
`define HIGH_RESET        32'h00000000
`define PAYLOAD_RESET     16'h0000
`define IDS_RESET         16'h0000
`define ALLOC_RESET       3'h0
`define UNLOCK_RESET      1'b0
`define MASK_RESET        3'h0
`define LINK_LSB          8
`define ALLOC_LSB         20
`define ST_SENT           0
`define ST_DROPPED        1
`define ST_LOCKED         2
`endif

// *** hdl/msi_subsystem_caps.v ***
// Interrupt message capability and subsystem identifier registers behind an AXI4-Lite slave
// Overview of operation
// - Interrupt header identifier reads 0x5
// - Interrupt link defaults zero, lockable write
// - Bit 16 enables interrupt messages
// - Requested count zero, one message only
// - Bit 23 reads one, wide capable
// - Lower address word aligned, bits 1:0 zero
// - Nonzero high address gives wide write
// - Zero high address gives narrow write
// - Downstream messages forwarded upstream, no decode
// - Payload low 16 bits, upper reads zero
// - Subsystem header identifier reads 0xD
// - Subsystem link defaults zero, lockable write
// - Subsystem vendor and subsystem identifiers lockable
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "msi_caps_map.vh"
module msi_subsystem_caps (
   input  wire        ref_clk,
   input  wire        reset_n,
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire        unlockIn,
   input  wire        msgEvent,
   output reg         msgValid,
   input  wire        msgReady,
   output reg  [63:0] msgAddr,
   output reg         msgWide,
   output reg  [31:0] msgData,
   output reg         msgUpstream,
   output reg         irq
);

   wire [7:0]  msiLink_r;
   wire        enable_r;
   wire [2:0]  allocCount_r;
   wire [29:0] addrLow_r;
   wire [31:0] addrHigh_r;
   wire [15:0] payload_r;
   wire [7:0]  subLink_r;
   wire [15:0] subVendor_r;
   wire [15:0] subId_r;
   wire        unlockSw_r;
   reg  [2:0]  status_r;
   wire [2:0]  mask_r;
   reg  [7:0]  wAddr_r;
   reg         awHeld_r;
   reg  [31:0] wData_r;
   reg  [3:0]  wStrb_r;
   reg         wHeld_r;
   reg  [2:0]  stSet;
   reg  [31:0] rdVal;
   reg         rdOk;
   reg         wrOk;
   wire        doWrite;
   wire        doRead;
   wire        unlocked;
   wire        swEvent;
   wire        evt;
   wire        stRead;
   wire        selCapCtrl;
   wire        selAddrLow;
   wire        selAddrHigh;
   wire        selPayload;
   wire        selSubHdr;
   wire        selSubIds;
   wire        selUnlock;
   wire        selMask;
   wire [31:0] lowMerged;
   wire [31:0] highMerged;
   wire [31:0] payloadMerged;
   wire [31:0] idsMerged;

   assign doWrite  = awHeld_r && wHeld_r && !s_axi_bvalid;
   assign doRead   = s_axi_arvalid && s_axi_arready;
   assign unlocked = unlockIn | unlockSw_r;
   assign swEvent  = doWrite && (wAddr_r == `OFS_EVENT) && wStrb_r[0] && wData_r[0];
   assign evt      = msgEvent | swEvent;
   assign stRead   = doRead && (s_axi_araddr == `OFS_IRQ_STATUS);
   assign selCapCtrl  = doWrite && (wAddr_r == `OFS_CAP_CTRL);
   assign selAddrLow  = doWrite && (wAddr_r == `OFS_ADDR_LOW);
   assign selAddrHigh = doWrite && (wAddr_r == `OFS_ADDR_HIGH);
   assign selPayload  = doWrite && (wAddr_r == `OFS_PAYLOAD);
   assign selSubHdr   = doWrite && (wAddr_r == `OFS_SUB_HDR);
   assign selSubIds   = doWrite && (wAddr_r == `OFS_SUB_IDS);
   assign selUnlock   = doWrite && (wAddr_r == `OFS_UNLOCK);
   assign selMask     = doWrite && (wAddr_r == `OFS_IRQ_MASK);

   // Byte lane merge
   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0]  be;
      integer i;
      begin
         for (i = 0; i < 4; i = i + 1) begin
            merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
         end
      end
   endfunction

   assign lowMerged     = merge({addrLow_r, 2'b00}, wData_r, wStrb_r);
   assign highMerged    = merge(addrHigh_r, wData_r, wStrb_r);
   assign payloadMerged = merge({16'h0000, payload_r}, wData_r, wStrb_r);
   assign idsMerged     = merge({subId_r, subVendor_r}, wData_r, wStrb_r);

   // Read decode
   always @* begin
      rdVal = 32'h00000000;
      rdOk  = 1'b1;
      case (s_axi_araddr)
         `OFS_CAP_CTRL:   rdVal = {8'h00, 1'b1, allocCount_r, 3'h0, enable_r, msiLink_r, `MSI_CAP_ID};
         `OFS_ADDR_LOW:   rdVal = {addrLow_r, 2'b00};
         `OFS_ADDR_HIGH:  rdVal = addrHigh_r;
         `OFS_PAYLOAD:    rdVal = {16'h0000, payload_r};
         `OFS_SUB_HDR:    rdVal = {16'h0000, subLink_r, `SUB_CAP_ID};
         `OFS_SUB_IDS:    rdVal = {subId_r, subVendor_r};
         `OFS_UNLOCK:     rdVal = {31'h00000000, unlockSw_r};
         `OFS_IRQ_STATUS: rdVal = {29'h00000000, status_r};
         `OFS_IRQ_MASK:   rdVal = {29'h00000000, mask_r};
         `OFS_EVENT:      rdVal = 32'h00000000;
         default:         rdOk  = 1'b0;
      endcase
   end

   always @* begin
      case (wAddr_r)
         `OFS_CAP_CTRL, `OFS_ADDR_LOW, `OFS_ADDR_HIGH, `OFS_PAYLOAD, `OFS_SUB_HDR, `OFS_SUB_IDS,
         `OFS_UNLOCK, `OFS_IRQ_STATUS, `OFS_IRQ_MASK, `OFS_EVENT: wrOk = 1'b1;
         default: wrOk = 1'b0;
      endcase
   end

   // Status event sources
   always @* begin
      stSet = 3'b000;
      if (evt && enable_r && !msgValid) begin
         stSet[`ST_SENT] = 1'b1;
      end
      if (evt && (!enable_r || msgValid)) begin
         stSet[`ST_DROPPED] = 1'b1;
      end
      if (doWrite && !unlocked && (wAddr_r == `OFS_SUB_IDS || wAddr_r == `OFS_SUB_HDR ||
          (wAddr_r == `OFS_CAP_CTRL && wStrb_r[1]))) begin
         stSet[`ST_LOCKED] = 1'b1;
      end
   end

   // AXI4-Lite channels
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'b00;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rresp   <= 2'b00;
         s_axi_rdata   <= 32'h00000000;
         awHeld_r      <= 1'b0;
         wHeld_r       <= 1'b0;
         wAddr_r       <= 8'h00;
         wData_r       <= 32'h00000000;
         wStrb_r       <= 4'h0;
      end else begin
         s_axi_awready <= !awHeld_r && !s_axi_awready && s_axi_awvalid;
         s_axi_wready  <= !wHeld_r && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld_r <= 1'b1;
            wAddr_r  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld_r <= 1'b1;
            wData_r <= s_axi_wdata;
            wStrb_r <= s_axi_wstrb;
         end
         if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wrOk ? 2'b00 : 2'b10;
            awHeld_r     <= 1'b0;
            wHeld_r      <= 1'b0;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (doRead) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rdVal;
            s_axi_rresp  <= rdOk ? 2'b00 : 2'b10;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Register fields
   cap_field_reg #(
      .WIDTH (8),
      .INIT  (`LINK_RESET)
   ) msiLinkReg (
      .ref_clk (ref_clk),
      .reset_n (reset_n),
      .load    (selCapCtrl && wStrb_r[1] && unlocked),
      .din     (wData_r[`LINK_LSB +: 8]),
      .q       (msiLink_r)
   );

   cap_field_reg #(
      .WIDTH (1),
      .INIT  (`ENABLE_RESET)
   ) enableReg (
      .ref_clk (ref_clk),
      .reset_n (reset_n),
      .load    (selCapCtrl && wStrb_r[2]),
      .din     (wData_r[`ENABLE_BIT]),
      .q       (enable_r)
   );

   cap_field_reg #(
      .WIDTH (3),
      .INIT  (`ALLOC_RESET)
   ) allocCountReg (
      .ref_clk (ref_clk),
      .reset_n (reset_n),
      .load    (selCapCtrl && wStrb_r[2]),
      .din     (wData_r[`ALLOC_LSB +: 3]),
      .q       (allocCount_r)
   );

   cap_field_reg #(
      .WIDTH (30),
      .INIT  (`ADDR_RESET)
   ) addrLowReg (
      .ref_clk (ref_clk),
      .reset_n (reset_n),
      .load    (selAddrLow),
      .din     (lowMerged[31:2]),
      .q       (addrLow_r)
   );

   cap_field_reg #(
      .WIDTH (32),
      .INIT  (`HIGH_RESET)
   ) addrHighReg (
      .ref_clk (ref_clk),
      .reset_n (reset_n),
      .load    (selAddrHigh),
      .din     (highMerged),
      .q       (addrHigh_r)
   );

   cap_field_reg #(
      .WIDTH (16),
      .INIT  (`PAYLOAD_RESET)
   ) payloadReg (
      .ref_clk (ref_clk),
      .reset_n (reset_n),
      .load    (selPayload),
      .din     (payloadMerged[15:0]),
      .q       (payload_r)
   );

   cap_field_reg #(
      .WIDTH (8),
      .INIT  (`LINK_RESET)
   ) subLinkReg (
      .ref_clk (ref_clk),
      .reset_n (reset_n),
      .load    (selSubHdr && wStrb_r[1] && unlocked),
      .din     (wData_r[`LINK_LSB +: 8]),
      .q       (subLink_r)
   );

   cap_field_reg #(
      .WIDTH (16),
      .INIT  (`IDS_RESET)
   ) subVendorReg (
      .ref_clk (ref_clk),
      .reset_n (reset_n),
      .load    (selSubIds && unlocked),
      .din     (idsMerged[15:0]),
      .q       (subVendor_r)
   );

   cap_field_reg #(
      .WIDTH (16),
      .INIT  (`IDS_RESET)
   ) subIdReg (
      .ref_clk (ref_clk),
      .reset_n (reset_n),
      .load    (selSubIds && unlocked),
      .din     (idsMerged[31:16]),
      .q       (subId_r)
   );

   cap_field_reg #(
      .WIDTH (1),
      .INIT  (`UNLOCK_RESET)
   ) unlockSwReg (
      .ref_clk (ref_clk),
      .reset_n (reset_n),
      .load    (selUnlock && wStrb_r[0]),
      .din     (wData_r[0]),
      .q       (unlockSw_r)
   );

   cap_field_reg #(
      .WIDTH (3),
      .INIT  (`MASK_RESET)
   ) maskReg (
      .ref_clk (ref_clk),
      .reset_n (reset_n),
      .load    (selMask && wStrb_r[0]),
      .din     (wData_r[2:0]),
      .q       (mask_r)
   );

   // Status, interrupt and message generation
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         status_r    <= 3'b000;
         irq         <= 1'b0;
         msgValid    <= 1'b0;
         msgAddr     <= 64'h0000000000000000;
         msgWide     <= 1'b0;
         msgData     <= 32'h00000000;
         msgUpstream <= 1'b0;
      end else begin
         status_r <= (stRead ? 3'b000 : status_r) | stSet;
         irq      <= |(((stRead ? 3'b000 : status_r) | stSet) & mask_r);
         if (evt && enable_r && !msgValid) begin
            msgValid    <= 1'b1;
            msgWide     <= (addrHigh_r != 32'h00000000);
            msgAddr     <= {addrHigh_r, addrLow_r, 2'b00};
            msgData     <= {16'h0000, payload_r};
            msgUpstream <= 1'b1;
         end else if (msgValid && msgReady) begin
            msgValid    <= 1'b0;
            msgUpstream <= 1'b0;
         end
      end
   end

endmodule

// One register field with load enable
module cap_field_reg #(
   parameter             WIDTH = 8,
   parameter [WIDTH-1:0] INIT  = {WIDTH{1'b0}}
) (
   input  wire             ref_clk,
   input  wire             reset_n,
   input  wire             load,
   input  wire [WIDTH-1:0] din,
   output reg  [WIDTH-1:0] q
);
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         q <= INIT;
      end else if (load) begin
         q <= din;
      end
   end
endmodule

// *** verif/msi_caps_assertions.sv ***
// Port checker for the capability register block
`timescale 1ns/10ps
module msi_caps_assertions (
   input logic        ref_clk,
   input logic        reset_n,
   input logic        s_axi_arvalid,
   input logic        s_axi_arready,
   input logic        s_axi_rvalid,
   input logic        s_axi_rready,
   input logic [31:0] s_axi_rdata,
   input logic [1:0]  s_axi_rresp,
   input logic        msgValid,
   input logic        msgReady,
   input logic [63:0] msgAddr,
   input logic        msgWide,
   input logic [31:0] msgData,
   input logic        msgUpstream
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   chk_msg_hold: assert property (msgValid && !msgReady |=> msgValid && $stable({msgAddr, msgData, msgWide}))
      else $error("message changed while waiting");
   chk_up_route: assert property (msgValid |-> msgUpstream)
      else $error("message not routed upstream");
   chk_wide_sel: assert property (msgValid |-> msgWide == (msgAddr[63:32] != 32'h0))
      else $error("address width wrong");
   chk_data_high: assert property (msgValid |-> msgData[31:16] == 16'h0)
      else $error("payload upper half set");
   chk_addr_align: assert property (msgValid |-> msgAddr[1:0] == 2'h0)
      else $error("message address unaligned");
   chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   chk_unmapped_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h0)
      else $error("unmapped read data nonzero");
   cover property (msgValid && msgWide);
   cover property (msgValid && !msgWide);
   cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
endmodule

// *** verif/root_sink_model.sv ***
// Root side sink taking interrupt writes after a set delay
`timescale 1ns/10ps
module root_sink_model (
   input  logic       ref_clk,
   input  logic       reset_n,
   input  logic       msgValid,
   input  logic [1:0] delay,
   output logic       msgReady
);
   logic [1:0] waitCnt_r;
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         waitCnt_r <= 2'h0;
         msgReady  <= 1'b0;
      end else if (msgValid && !msgReady) begin
         msgReady  <= (waitCnt_r == delay);
         waitCnt_r <= waitCnt_r + 2'h1;
      end else begin
         msgReady  <= 1'b0;
         waitCnt_r <= 2'h0;
      end
   end
endmodule

// *** verif/test_msi_and_subsystem_capability_regs.sv ***
// Bench for the interrupt and subsystem capability registers
`timescale 1ns/10ps
module test_msi_and_subsystem_capability_regs;
   logic        ref_clk, reset_n, unlockIn, msgEvent, msgReady, msgValid, msgWide, msgUpstream, irq;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, msgData;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, delay;
   logic [63:0] msgAddr;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   int          failures = 0, check_count = 0;
   logic [7:0]  ofs[6] = '{8'hd0, 8'hd4, 8'hd8, 8'hdc, 8'hf0, 8'hf4};
   logic [31:0] rst[6] = '{32'h00800005, 32'h0, 32'h0, 32'h0, 32'h0000000d, 32'h0};
   msi_subsystem_caps DUT (.*);
   root_sink_model sink (.*);
   task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict;
      $display("mismatches %0d comparisons %0d", failures, check_count);
      if (failures == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic stall;
      failures++;
      $display("unexpected at %0t: wait timed out", $time);
      give_verdict;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         n++;
      end while (!s_axi_bvalid && n < 40);
      if (!s_axi_bvalid) stall;
      s_axi_bready <= 1'b0;
      cmp(s_axi_bresp, 2'b00);
      @(posedge ref_clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'b00);
      int n = 0;
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         n++;
      end while (!s_axi_rvalid && n < 40);
      if (!s_axi_rvalid) stall;
      s_axi_rready <= 1'b0;
      cmp({s_axi_rresp, s_axi_rdata}, {er, e});
      @(posedge ref_clk);
   endtask
   task automatic msg(input logic [63:0] ea, input logic ew);
      int n = 0;
      while (!msgValid && n < 40) begin
         @(posedge ref_clk);
         n++;
      end
      if (!msgValid) stall;
      cmp(msgAddr, ea);
      cmp({msgWide, msgUpstream, msgData}, {ew, 1'b1, 32'h0000ffff});
      while (!(msgValid && msgReady) && n < 80) begin
         @(posedge ref_clk);
         n++;
      end
      if (n >= 80) stall;
      @(posedge ref_clk);
      cmp(msgValid, 1'b0);
   endtask
   task automatic pulse;
      msgEvent <= 1'b1;
      @(posedge ref_clk);
      msgEvent <= 1'b0;
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   initial begin
      {reset_n, unlockIn, msgEvent, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 8'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      s_axi_wstrb = 4'hf;
      delay = 2'h3;
      repeat (2) @(posedge ref_clk);
      reset_n <= 1'b1;
      @(posedge ref_clk);
      foreach (ofs[i]) rd(ofs[i], rst[i]);
      rd(8'hc0, 32'h0, 2'b10);
      wr(8'hf4, 32'hffffffff);
      rd(8'hf4, 32'h0);
      wr(8'hd0, 32'hffffffff);
      rd(8'hd0, 32'h00f10005);
      cmp(irq, 1'b0);
      rd(8'he4, 32'h4);
      rd(8'he4, 32'h0);
      unlockIn <= 1'b1;
      wr(8'hf4, 32'h12345678);
      rd(8'hf4, 32'h12345678);
      wr(8'hf0, 32'hffffffff);
      rd(8'hf0, 32'h0000ff0d);
      wr(8'hd0, 32'hffffffff);
      rd(8'hd0, 32'h00f1ff05);
      unlockIn <= 1'b0;
      wr(8'he0, 32'h1);
      wr(8'hf4, 32'h89abcdef);
      rd(8'hf4, 32'h89abcdef);
      wr(8'he0, 32'h0);
      rd(8'he0, 32'h0);
      wr(8'hd4, 32'hffffffff);
      rd(8'hd4, 32'hfffffffc);
      wr(8'hdc, 32'hffffffff);
      rd(8'hdc, 32'h0000ffff);
      wr(8'he8, 32'h1);
      delay <= 2'h0;
      pulse;
      msg(64'hfffffffc, 1'b0);
      cmp(irq, 1'b1);
      rd(8'he4, 32'h1);
      repeat (2) @(posedge ref_clk);
      cmp(irq, 1'b0);
      wr(8'hd8, 32'h1);
      delay <= 2'h3;
      wr(8'hec, 32'h1);
      msg(64'h00000001fffffffc, 1'b1);
      wr(8'hd0, 32'h0);
      pulse;
      repeat (3) @(posedge ref_clk);
      cmp(msgValid, 1'b0);
      rd(8'he4, 32'h7);
      give_verdict;
   end
endmodule
bind msi_subsystem_caps msi_caps_assertions chk (.*);
